// ===== rtl/mcp_pkg.sv
// package of constants and types for the 16-bit math coprocessor
// Function
// - multiply or divide, signed or unsigned, optional accumulate
// - operation runs on its own once started
// - five host readable and writable registers
// - data registers hold integers, radix after bit 0
// - operand a is multiplicand or divisor
// - operand b is multiplier, takes division remainder
// - accumulator halves hold product, numerator, quotient
// - fractional numerator in low half excludes sign
// - fractional divide moves low half, quotient, remainder
// - signed values use two's complement encoding
// - accumulator 32 bits at 0x40-0x43, msb first
// - control bits mode, divide, accumulate, compensation, trigger
// - mode bit selects unsigned or signed registers
// - flag register reports last operation status
// - trigger or operand write starts function
// - completion, zero divisor, overflow flags, write-one clears
// - sign flag read-only, zero remainder flag
// - operands 16 bits at 0x45 and 0x47
package mcp_pkg;
    localparam logic [7:0] ADDR_C3 = 8'h40;
    localparam logic [7:0] ADDR_C2 = 8'h41;
    localparam logic [7:0] ADDR_C1 = 8'h42;
    localparam logic [7:0] ADDR_C0 = 8'h43;
    localparam logic [7:0] ADDR_CTRL = 8'h44;
    localparam logic [7:0] ADDR_A_HI = 8'h45;
    localparam logic [7:0] ADDR_A_LO = 8'h46;
    localparam logic [7:0] ADDR_B_HI = 8'h47;
    localparam logic [7:0] ADDR_B_LO = 8'h48;
    localparam logic [7:0] ADDR_FLAG = 8'h49;
    localparam int CTRL_SIGN_BIT = 7;
    localparam int CTRL_DIV_BIT = 6;
    localparam int CTRL_ACC_BIT = 5;
    localparam int CTRL_COMP_BIT = 4;
    localparam int CTRL_TRIG_BIT = 3;
    localparam int FLAG_NEG_BIT = 7;
    localparam int FLAG_RZ_BIT = 6;
    localparam int FLAG_OVF_BIT = 2;
    localparam int FLAG_DZ_BIT = 1;
    localparam int FLAG_DONE_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] FLAG_RESET = 8'h00;
    localparam logic [7:0] CTRL_WMASK = 8'hF0;
    localparam logic [5:0] DIV_STEPS = 6'h20;

    typedef struct packed {
        logic sel;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mcp_bus_t;

    typedef enum logic [1:0] {
        MCP_IDLE,
        MCP_MUL,
        MCP_DSTART,
        MCP_DRUN
    } mcp_state_t;
endpackage

// ===== rtl/mcp_divider.sv
// unsigned 32 by 16 restoring divider
`timescale 1ns/1ps
module mcp_divider (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic start,
    input wire logic [31:0] num,
    input wire logic [15:0] den,
    output logic done,
    output logic [31:0] quo,
    output logic [15:0] rem
);
    import mcp_pkg::*;

    logic [31:0] next_quo;
    logic [16:0] rem_w;
    logic [16:0] next_rem_w;
    logic [15:0] den_q;
    logic [15:0] next_den_q;
    logic [5:0] count;
    logic [5:0] next_count;
    logic next_done;
    logic [16:0] trial;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_quo = quo;
        next_rem_w = rem_w;
        next_den_q = den_q;
        next_count = count;
        next_done = 1'b0;
        trial = {rem_w[15:0], quo[31]};
        if (start) begin
            next_quo = num;
            next_rem_w = 17'h00000;
            next_den_q = den;
            next_count = DIV_STEPS;
        end else if (count != 6'h00) begin
            if (trial >= {1'b0, den_q}) begin
                next_rem_w = trial - {1'b0, den_q};
                next_quo = {quo[30:0], 1'b1};
            end else begin
                next_rem_w = trial;
                next_quo = {quo[30:0], 1'b0};
            end
            next_count = count - 6'h01;
            next_done = (count == 6'h01);
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            quo <= 32'h00000000;
            rem_w <= 17'h00000;
            den_q <= 16'h0000;
            count <= 6'h00;
            done <= 1'b0;
        end else if (clk_en) begin
            quo <= next_quo;
            rem_w <= next_rem_w;
            den_q <= next_den_q;
            count <= next_count;
            done <= next_done;
        end
    end

    assign rem = rem_w[15:0];
endmodule // mcp_divider

// ===== rtl/mcp_coproc.sv
// 16-bit math coprocessor with byte register port
`timescale 1ns/1ps
module mcp_coproc (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire mcp_pkg::mcp_bus_t bus,
    output logic [7:0] rdata,
    output logic busy
);
    import mcp_pkg::*;

    function automatic logic [31:0] mag32(input logic [31:0] v, input logic s);
        mag32 = (s && v[31]) ? (32'h00000000 - v) : v;
    endfunction

    function automatic logic [31:0] neg_if(input logic [31:0] v, input logic n);
        neg_if = n ? (32'h00000000 - v) : v;
    endfunction

    mcp_state_t state, next_state;
    logic [15:0] a_reg, next_a;
    logic [15:0] b_reg, next_b;
    logic [31:0] c_reg, next_c;
    logic [7:0] ctrl, next_ctrl;
    logic [7:0] flag, next_flag;
    logic [7:0] next_rdata;
    logic wr;
    logic [7:0] mode;
    logic trig, start_mul, start_div;
    logic div_start, div_done;
    logic [31:0] div_num, div_quo;
    logic [15:0] div_rem;
    logic sg;
    logic [31:0] prod;
    logic [32:0] usum;
    logic [31:0] q_s, r_s, a_mag;
    logic q_neg, n_neg;
    logic [7:0] fset, fclr;

    ////////////////////////////////////////////////////////////////////////
    // operand selection for the divider
    assign sg = ctrl[CTRL_SIGN_BIT];
    assign a_mag = mag32({{16{a_reg[15]}}, a_reg}, sg);
    assign div_num = ctrl[CTRL_ACC_BIT] ? {1'b0, c_reg[14:0], 16'h0000} : mag32(c_reg, sg);
    assign div_start = (state == MCP_DSTART);

    mcp_divider u_div (
        .clock(clock),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .start(div_start),
        .num(div_num),
        .den(a_mag[15:0]),
        .done(div_done),
        .quo(div_quo),
        .rem(div_rem)
    );

    ////////////////////////////////////////////////////////////////////////
    // arithmetic
    always_comb begin
        if (sg) begin
            prod = 32'($signed(a_reg) * $signed(b_reg));
        end else begin
            prod = {16'h0000, a_reg} * {16'h0000, b_reg};
        end
        usum = {1'b0, c_reg} + {1'b0, prod};
        n_neg = sg && !ctrl[CTRL_ACC_BIT] && c_reg[31];
        q_neg = sg && (a_reg[15] != (ctrl[CTRL_ACC_BIT] ? 1'b0 : c_reg[31]));
        q_s = neg_if(div_quo, q_neg);
        r_s = neg_if({16'h0000, div_rem}, n_neg);
        if (sg && ctrl[CTRL_COMP_BIT] && q_neg && (div_rem != 16'h0000)) begin
            q_s = q_s - 32'h00000001;
            r_s = a_mag - {16'h0000, div_rem};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register port, sequencing and flags
    always_comb begin
        next_state = state;
        next_a = a_reg;
        next_b = b_reg;
        next_c = c_reg;
        next_ctrl = ctrl;
        fset = 8'h00;
        fclr = 8'h00;
        wr = bus.sel && bus.wr;
        trig = wr && (bus.addr == ADDR_CTRL) && bus.wdata[CTRL_TRIG_BIT];
        mode = trig ? bus.wdata : ctrl;
        if (wr) begin
            case (bus.addr)
                ADDR_C3: next_c[31:24] = bus.wdata;
                ADDR_C2: next_c[23:16] = bus.wdata;
                ADDR_C1: next_c[15:8] = bus.wdata;
                ADDR_C0: next_c[7:0] = bus.wdata;
                ADDR_CTRL: next_ctrl = bus.wdata & CTRL_WMASK;
                ADDR_A_HI: next_a[15:8] = bus.wdata;
                ADDR_A_LO: next_a[7:0] = bus.wdata;
                ADDR_B_HI: next_b[15:8] = bus.wdata;
                ADDR_B_LO: next_b[7:0] = bus.wdata;
                ADDR_FLAG: fclr = bus.wdata & 8'h07;
                default: ;
            endcase
        end
        start_mul = !mode[CTRL_DIV_BIT] && (trig || (wr && bus.addr == ADDR_B_LO));
        start_div = mode[CTRL_DIV_BIT] && (trig || (wr && bus.addr == ADDR_A_LO
                    && !mode[CTRL_ACC_BIT]));
        case (state)
            MCP_IDLE: begin
                if (start_mul) begin
                    next_state = MCP_MUL;
                end else if (start_div) begin
                    next_state = MCP_DSTART;
                end
            end
            MCP_MUL: begin
                next_state = MCP_IDLE;
                fset[FLAG_DONE_BIT] = 1'b1;
                if (ctrl[CTRL_ACC_BIT]) begin
                    next_c = usum[31:0];
                    if (sg) begin
                        fset[FLAG_OVF_BIT] = (c_reg[31] == prod[31]) && (usum[31] != c_reg[31]);
                    end else begin
                        fset[FLAG_OVF_BIT] = usum[32];
                    end
                    fset[FLAG_NEG_BIT] = sg && usum[31];
                end else begin
                    next_c = prod;
                    fset[FLAG_NEG_BIT] = sg && prod[31];
                end
            end
            MCP_DSTART: begin
                if (a_reg == 16'h0000) begin
                    next_state = MCP_IDLE;
                    fset[FLAG_DZ_BIT] = 1'b1;
                    fset[FLAG_DONE_BIT] = 1'b1;
                end else begin
                    next_state = MCP_DRUN;
                end
            end
            MCP_DRUN: begin
                if (div_done) begin
                    next_state = MCP_IDLE;
                    fset[FLAG_DONE_BIT] = 1'b1;
                    fset[FLAG_RZ_BIT] = (div_rem == 16'h0000);
                    next_b = r_s[15:0];
                    if (ctrl[CTRL_ACC_BIT]) begin
                        next_c = {c_reg[15:0], q_s[15:0]};
                        fset[FLAG_OVF_BIT] = (div_quo[31:16] != 16'h0000);
                        fset[FLAG_NEG_BIT] = sg && q_s[15];
                    end else begin
                        next_c = q_s;
                        fset[FLAG_NEG_BIT] = sg && q_s[31];
                    end
                end
            end
            default: next_state = MCP_IDLE;
        endcase
        if (fset[FLAG_DONE_BIT]) begin
            next_flag = (flag & ~fclr & 8'h07) | fset;
        end else begin
            next_flag = flag & ~fclr;
        end
    end

    always_comb begin
        case (bus.addr)
            ADDR_C3: next_rdata = c_reg[31:24];
            ADDR_C2: next_rdata = c_reg[23:16];
            ADDR_C1: next_rdata = c_reg[15:8];
            ADDR_C0: next_rdata = c_reg[7:0];
            ADDR_CTRL: next_rdata = ctrl & CTRL_WMASK;
            ADDR_A_HI: next_rdata = a_reg[15:8];
            ADDR_A_LO: next_rdata = a_reg[7:0];
            ADDR_B_HI: next_rdata = b_reg[15:8];
            ADDR_B_LO: next_rdata = b_reg[7:0];
            ADDR_FLAG: next_rdata = flag;
            default: next_rdata = 8'h00;
        endcase
    end

    // data registers keep their power-up content through reset
    always_ff @(posedge clock) begin
        if (clk_en) begin
            a_reg <= next_a;
            b_reg <= next_b;
            c_reg <= next_c;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state <= MCP_IDLE;
            ctrl <= CTRL_RESET;
            flag <= FLAG_RESET;
            rdata <= 8'h00;
        end else if (clk_en) begin
            state <= next_state;
            ctrl <= next_ctrl;
            flag <= next_flag;
            rdata <= next_rdata;
        end
    end

    assign busy = (state != MCP_IDLE);
endmodule // mcp_coproc

// ===== verification/mcp_coproc_checker.sv
// assertions on the coprocessor register port
`timescale 1ns/1ps
module mcp_coproc_checker (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire mcp_pkg::mcp_bus_t bus,
    input wire logic [7:0] rdata,
    input wire logic busy
);
    import mcp_pkg::*;
    logic [3:0] mode;
    logic [3:0] next_mode;
    logic wr_go;
    assign wr_go = bus.sel && bus.wr && clk_en && !busy;
    always_comb begin
        next_mode = mode;
        if (bus.sel && bus.wr && clk_en && bus.addr == ADDR_CTRL) begin
            next_mode = bus.wdata[7:4];
        end
    end
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            mode <= 4'h0;
        end else begin
            mode <= next_mode;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence s_short_op;
        busy ##1 !busy;
    endsequence
    a_mul_one_cycle: assert property (wr_go && bus.addr == ADDR_B_LO && !mode[2] |=> s_short_op)
        else $error("multiply did not take one cycle");
    a_integer_divide_on_a: assert property (wr_go && bus.addr == ADDR_A_LO && mode[2:1] == 2'h2 |=> busy)
        else $error("operand a write did not start divide");
    a_fractional_divide_not_a: assert property (wr_go && bus.addr == ADDR_A_LO && mode[2:1] == 2'h3 |=> !busy)
        else $error("operand a write started fractional divide");
    a_trig_start: assert property (wr_go && bus.addr == ADDR_CTRL && bus.wdata[3] |=> busy)
        else $error("trigger did not start");
    a_op_bounded: assert property ($rose(busy) |-> ##[1:40] !busy)
        else $error("operation did not end");
    a_ctrl_readback: assert property (bus.addr == ADDR_CTRL && !(bus.sel && bus.wr)
        |=> rdata == {mode, 4'h0})
        else $error("control readback wrong");
    a_flag_unused: assert property (bus.addr == ADDR_FLAG |=> rdata[5:3] == 3'h0)
        else $error("unused flag bits set");
    a_unmapped_zero: assert property (bus.addr < 8'h40 || bus.addr > 8'h49 |=> rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule // mcp_coproc_checker
bind mcp_coproc mcp_coproc_checker chk (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
    .bus(bus), .rdata(rdata), .busy(busy));

// ===== verification/mcp_host.sv
// host processor model on the coprocessor register port
`timescale 1ns/1ps
module mcp_host (
    input wire logic clock,
    input wire logic [7:0] rdata,
    input wire logic busy,
    output mcp_pkg::mcp_bus_t bus
);
    import mcp_pkg::*;
    initial begin
        bus = '0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        bus <= '{sel: 1'b1, wr: 1'b1, addr: a, wdata: d};
        @(posedge clock);
        bus <= '{sel: 1'b0, wr: 1'b0, addr: 8'h00, wdata: ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        bus <= '{sel: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        repeat (2) @(posedge clock);
        d = rdata;
        bus <= '{sel: 1'b0, wr: 1'b0, addr: 8'h00, wdata: 8'hFF};
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 60; i++) begin
            @(posedge clock);
            if (busy === 1'b0) break;
        end
    endtask
endmodule // mcp_host

// ===== verification/math_coprocessor_16bit_bench.sv
// self-checking bench for the math coprocessor
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
module math_coprocessor_16bit_bench;
    import mcp_pkg::*;
    logic clock, sys_rst, clk_en, busy;
    mcp_bus_t bus;
    logic [7:0] rdata;
    int err_total, cmp_count;
    mcp_host host (.clock(clock), .rdata(rdata), .busy(busy), .bus(bus));
    mcp_coproc uut (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .bus(bus),
        .rdata(rdata), .busy(busy));
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        host.wr(a, v[15:8]);
        host.wr(a + 8'h01, v[7:0]);
    endtask
    task automatic wr32(input logic [31:0] v);
        wr16(ADDR_C3, v[31:16]);
        wr16(ADDR_C1, v[15:0]);
    endtask
    task automatic rc(input logic [7:0] a, input int n, input logic [31:0] e, input string s,
        input logic [31:0] m = 32'hFFFF_FFFF);
        logic [31:0] got;
        logic [7:0] b;
        got = '0;
        for (int i = 0; i < n; i++) begin
            host.rd(a + i[7:0], b);
            got = {got[23:0], b};
        end
        `CHK(s, e, got & m)
    endtask
    task automatic t_mul();
        rc(ADDR_CTRL, 1, 32'h0, "ctrl");
        rc(ADDR_FLAG, 1, 32'h0, "flags");
        wr16(ADDR_A_HI, 16'h1234);
        wr16(ADDR_B_HI, 16'h5678);
        host.wait_idle();
        rc(ADDR_C3, 4, 32'h0626_0060, "uprod");
        rc(ADDR_FLAG, 1, 32'h01, "uflag", 32'hBF);
        host.wr(ADDR_CTRL, 8'h80);
        wr16(ADDR_A_HI, 16'hFFFD);
        wr16(ADDR_B_HI, 16'h0005);
        host.wait_idle();
        rc(ADDR_C3, 4, 32'hFFFF_FFF1, "sprod");
        rc(ADDR_FLAG, 1, 32'h81, "sflag", 32'hBF);
        host.wr(ADDR_FLAG, 8'hFF);
        rc(ADDR_FLAG, 1, 32'h80, "clrflag", 32'hBF);
    endtask
    task automatic t_mac();
        host.wr(ADDR_CTRL, 8'h20);
        wr32(32'hFFFF_FFFF);
        wr16(ADDR_A_HI, 16'h0001);
        wr16(ADDR_B_HI, 16'h0001);
        host.wait_idle();
        rc(ADDR_C3, 4, 32'h0, "macwrap");
        rc(ADDR_FLAG, 1, 32'h05, "ovf", 32'hBF);
        host.wr(ADDR_CTRL, 8'h28);
        host.wait_idle();
        rc(ADDR_C3, 4, 32'h1, "mactrig");
        rc(ADDR_FLAG, 1, 32'h05, "ovfsticky", 32'hBF);
        host.wr(ADDR_FLAG, 8'h04);
        rc(ADDR_FLAG, 1, 32'h01, "ovfclr", 32'hBF);
    endtask
    task automatic t_div();
        host.wr(ADDR_CTRL, 8'h40);
        wr32(32'h0000_03E8);
        wr16(ADDR_A_HI, 16'h0007);
        host.wait_idle();
        rc(ADDR_C3, 4, 32'h0000_008E, "uquot");
        rc(ADDR_B_HI, 2, 32'h0006, "urem");
        rc(ADDR_FLAG, 1, 32'h01, "dflag");
        wr16(ADDR_A_HI, 16'h0000);
        host.wait_idle();
        rc(ADDR_C3, 4, 32'h0000_008E, "dzkeep");
        rc(ADDR_FLAG, 1, 32'h03, "dzflag", 32'h3F);
        host.wr(ADDR_CTRL, 8'hD0);
        wr32(32'hFFFF_FF9C);
        wr16(ADDR_A_HI, 16'h0007);
        host.wait_idle();
        rc(ADDR_C3, 4, 32'hFFFF_FFF1, "squot");
        rc(ADDR_B_HI, 2, 32'h0005, "srem");
    endtask
    task automatic t_fractional_divide();
        host.wr(ADDR_FLAG, 8'h07);
        host.wr(ADDR_CTRL, 8'h60);
        wr32(32'h1111_4000);
        wr16(ADDR_A_HI, 16'h8000);
        host.wr(ADDR_CTRL, 8'h68);
        host.wait_idle();
        rc(ADDR_C3, 4, 32'h4000_8000, "fquot");
        rc(ADDR_B_HI, 2, 32'h0000, "frem");
        rc(ADDR_FLAG, 1, 32'h41, "fflag");
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        tally_and_finish();
    end
    initial begin
        sys_rst = 1'b1;
        clk_en = 1'b1;
        err_total = 0;
        cmp_count = 0;
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        t_mul();
        t_mac();
        t_div();
        t_fractional_divide();
        tally_and_finish();
    end
endmodule // math_coprocessor_16bit_bench
